// File: rtl/cappwm_channel.sv
`timescale 1ns/1ns
module cappwm_channel (
  input  wire logic       i_clk,
  input  wire logic       i_resetn,
  input  wire logic [7:0] i_mode,
  input  wire logic [7:0] i_count,
  input  wire logic       i_count_inc,
  input  wire logic       i_overflow,
  input  wire logic       i_low_wr,
  input  wire logic       i_high_wr,
  input  wire logic [7:0] i_wdata,
  output logic      [7:0] o_low,
  output logic      [7:0] o_high,
  output logic            o_pin
);
  import cappwm_pkg::*;

  logic [7:0]     low_ff;
  logic [7:0]     high_ff;
  cappwm_pin_type pin_ff;
  cappwm_pin_type nxt_pin;
  logic           active;
  logic           match;

  assign active = i_mode[COMPARE_ENABLE_BIT] && i_mode[MODULATION_ENABLE_BIT]
                  && !i_mode[WIDE_SELECT_BIT];
  assign match  = i_count_inc && (i_count == low_ff);

  // ************************************************************
  // Compare bytes, low byte reloaded from high byte at low byte overflow in 8-bit mode.
  // ************************************************************
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      low_ff <= COMPARE_RESET_VALUE;
    end else if (i_low_wr) begin
      low_ff <= i_wdata;
    end else if (i_overflow && active) begin
      low_ff <= high_ff;
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      high_ff <= COMPARE_RESET_VALUE;
    end else if (i_high_wr) begin
      high_ff <= i_wdata;
    end
  end

  // ************************************************************
  // Output pin: overflow clears, match sets, disabled stays low.
  // ************************************************************
  always_comb begin
    nxt_pin = pin_ff;
    case (pin_ff)
      CAPPWM_PIN_LOW: begin
        if (match && !i_overflow) begin
          nxt_pin = CAPPWM_PIN_HIGH;
        end
      end
      CAPPWM_PIN_HIGH: begin
        if (i_overflow) begin
          nxt_pin = CAPPWM_PIN_LOW;
        end
      end
      default: nxt_pin = CAPPWM_PIN_LOW;
    endcase
    if (!active) begin
      nxt_pin = CAPPWM_PIN_LOW;
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      pin_ff <= CAPPWM_PIN_LOW;
    end else begin
      pin_ff <= nxt_pin;
    end
  end

  // A match drives the pin high in the cycle it is seen, so the high time spans 256 minus the compare value.
  assign o_pin  = (pin_ff == CAPPWM_PIN_HIGH) || (active && match);
  assign o_low  = low_ff;
  assign o_high = high_ff;

  sequence s_wrap;
    i_overflow && active && !i_low_wr;
  endsequence

  property p_reload;
    @(posedge i_clk) disable iff (!i_resetn)
      s_wrap |=> (low_ff == $past(high_ff));
  endproperty
  a_reload: assert property (p_reload) else $error("Compare low byte not reloaded.");

  property p_disabled_low;
    @(posedge i_clk) disable iff (!i_resetn)
      !active |=> (pin_ff == CAPPWM_PIN_LOW);
  endproperty
  a_disabled_low: assert property (p_disabled_low) else $error("Pin high while disabled.");

  property p_clear;
    @(posedge i_clk) disable iff (!i_resetn)
      i_overflow |=> (pin_ff == CAPPWM_PIN_LOW);
  endproperty
  a_clear: assert property (p_clear) else $error("Pin not cleared at overflow.");

  property p_set;
    @(posedge i_clk) disable iff (!i_resetn)
      active && match && !i_overflow ##1 active |-> (pin_ff == CAPPWM_PIN_HIGH);
  endproperty
  a_set: assert property (p_set) else $error("Pin not set at match.");

endmodule : cappwm_channel

// File: rtl/cappwm_modereg.sv
`timescale 1ns/1ns
module cappwm_modereg (
  input  wire logic       i_clk,
  input  wire logic       i_resetn,
  input  wire logic       i_mode_wr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_low_wr,
  input  wire logic       i_high_wr,
  output logic      [7:0] o_mode
);
  import cappwm_pkg::*;

  logic [7:0] mode_ff;
  logic [7:0] nxt_mode;

  // ************************************************************
  // Mode register with compare enable side effects.
  // ************************************************************
  always_comb begin
    nxt_mode = mode_ff;
    if (i_mode_wr) begin
      nxt_mode = i_wdata;
    end
    if (i_low_wr) begin
      nxt_mode[COMPARE_ENABLE_BIT] = 1'b0;
    end
    if (i_high_wr) begin
      nxt_mode[COMPARE_ENABLE_BIT] = 1'b1;
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      mode_ff <= MODE_RESET_VALUE;
    end else begin
      mode_ff <= nxt_mode;
    end
  end

  assign o_mode = mode_ff;

  property p_low_clears;
    @(posedge i_clk) disable iff (!i_resetn)
      i_low_wr && !i_high_wr |=> !mode_ff[COMPARE_ENABLE_BIT];
  endproperty
  a_low_clears: assert property (p_low_clears) else $error("Low write did not clear enable.");

  property p_high_sets;
    @(posedge i_clk) disable iff (!i_resetn)
      i_high_wr |=> mode_ff[COMPARE_ENABLE_BIT];
  endproperty
  a_high_sets: assert property (p_high_sets) else $error("High write did not set enable.");

endmodule : cappwm_modereg

// File: rtl/cappwm_pkg.sv
package cappwm_pkg;

  // ************************************************************
  // Register map and field layout.
  // ************************************************************
  localparam logic [7:0] MODULE0_MODE_CONTROL_ADDR = 8'hDA;
  localparam logic [7:0] MODULE1_MODE_CONTROL_ADDR = 8'hDB;
  localparam logic [7:0] MODULE2_MODE_CONTROL_ADDR = 8'hDC;
  localparam logic [7:0] MODE_RESET_VALUE          = 8'h00;
  localparam int         WIDE_SELECT_BIT           = 7;
  localparam int         COMPARE_ENABLE_BIT        = 6;
  localparam int         MODULATION_ENABLE_BIT     = 1;
  localparam logic [7:0] COMPARE_RESET_VALUE       = 8'h00;
  localparam logic [7:0] COUNT_MAX                 = 8'hFF;
  localparam logic [7:0] COUNT_ZERO                = 8'h00;
  localparam int         NUM_MODULES               = 3;

  // ************************************************************
  // Output pin state.
  // ************************************************************
  typedef enum logic [1:0] {
    CAPPWM_PIN_LOW  = 2'b01,
    CAPPWM_PIN_HIGH = 2'b10
  } cappwm_pin_type;

endpackage : cappwm_pkg

// File: rtl/cappwm_top.sv
`timescale 1ns/1ns
// Overview of operation
// - Each module runs its own modulation from the shared counter and drives only its own pin.
// - The output period is one full cycle of the shared counter low byte, so it follows the counter timebase.
// - In 8-bit mode the pin goes high when the counter low byte equals the compare low byte.
// - In 8-bit mode the pin goes low when the counter low byte overflows.
// - In 8-bit mode, at the wrap from 0xFF to 0x00 the compare low byte is loaded from the compare high byte by hardware.
// - The 8-bit mode needs compare enable and modulation enable set and the wide select clear.
// - Writing the compare low byte clears compare enable and writing the compare high byte sets it.
// - The high fraction equals 256 minus the compare high value, over 256.
// - With compare enable clear the pin stays low.
module cappwm_top #(
  parameter int NMOD = cappwm_pkg::NUM_MODULES
) (
  input  wire logic            I_REF_CLK,
  input  wire logic            I_RESETN,
  input  wire logic            i_sfr_wr,
  input  wire logic [7:0]      i_sfr_addr,
  input  wire logic [7:0]      i_sfr_wdata,
  output logic      [7:0]      o_sfr_rdata,
  input  wire logic [NMOD-1:0] i_low_wr,
  input  wire logic [NMOD-1:0] i_high_wr,
  input  wire logic [7:0]      i_counter_low_byte,
  input  wire logic            i_counter_inc,
  output logic      [NMOD-1:0] o_module_output_pin,
  output logic      [8*NMOD-1:0] o_compare_low_byte,
  output logic      [8*NMOD-1:0] o_compare_high_byte
);
  import cappwm_pkg::*;

  if (NMOD < 1 || NMOD > NUM_MODULES) begin : g_bad_nmod
    $error("NMOD out of range.");
  end

  logic [7:0] mode [NMOD];
  logic       overflow;

  // A wrap is an increment taken while the low byte stands at its maximum.
  assign overflow = i_counter_inc && (i_counter_low_byte == COUNT_MAX);

  // ************************************************************
  // Per module register and modulator.
  // ************************************************************
  for (genvar m = 0; m < NMOD; m++) begin : g_mod
    logic mode_wr;
    assign mode_wr = i_sfr_wr && (i_sfr_addr == MODULE0_MODE_CONTROL_ADDR + 8'(m));

    cappwm_modereg u_modereg (
      .i_clk     (I_REF_CLK),
      .i_resetn  (I_RESETN),
      .i_mode_wr (mode_wr),
      .i_wdata   (i_sfr_wdata),
      .i_low_wr  (i_low_wr[m]),
      .i_high_wr (i_high_wr[m]),
      .o_mode    (mode[m])
    );

    cappwm_channel u_channel (
      .i_clk       (I_REF_CLK),
      .i_resetn    (I_RESETN),
      .i_mode      (mode[m]),
      .i_count     (i_counter_low_byte),
      .i_count_inc (i_counter_inc),
      .i_overflow  (overflow),
      .i_low_wr    (i_low_wr[m]),
      .i_high_wr   (i_high_wr[m]),
      .i_wdata     (i_sfr_wdata),
      .o_low       (o_compare_low_byte[8*m +: 8]),
      .o_high      (o_compare_high_byte[8*m +: 8]),
      .o_pin       (o_module_output_pin[m])
    );
  end

  // ************************************************************
  // Mode register read back.
  // ************************************************************
  always_comb begin
    o_sfr_rdata = 8'h00;
    for (int k = 0; k < NMOD; k++) begin
      if (i_sfr_addr == MODULE0_MODE_CONTROL_ADDR + 8'(k)) begin
        o_sfr_rdata = mode[k];
      end
    end
  end

endmodule : cappwm_top

// File: tb/tb_top.sv
`timescale 1ns/1ns
`define CHK(what, exp, got) begin checked++; if ((got) !== (exp)) begin n_mismatch++; \
  $display("Error %s expected %0h seen %0h", what, exp, got); end end
module tb_top;
  import cappwm_pkg::*;
  // ************************************************************
  // Stimulus signals and design instance.
  // ************************************************************
  logic        clk;
  logic        resetn;
  logic        sfr_wr;
  logic [7:0]  sfr_addr;
  logic [7:0]  sfr_wdata;
  logic [7:0]  sfr_rdata;
  logic [2:0]  low_wr;
  logic [2:0]  high_wr;
  logic [7:0]  count;
  logic        count_inc;
  logic [2:0]  pin;
  logic [23:0] cmp_low;
  int          n_mismatch;
  int          checked;
  int          highs [3];

  cappwm_top u_cappwm_top (
    .I_REF_CLK           (clk),
    .I_RESETN            (resetn),
    .i_sfr_wr            (sfr_wr),
    .i_sfr_addr          (sfr_addr),
    .i_sfr_wdata         (sfr_wdata),
    .o_sfr_rdata         (sfr_rdata),
    .i_low_wr            (low_wr),
    .i_high_wr           (high_wr),
    .i_counter_low_byte  (count),
    .i_counter_inc       (count_inc),
    .o_module_output_pin (pin),
    .o_compare_low_byte  (cmp_low),
    .o_compare_high_byte ()
  );

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // ************************************************************
  // Access tasks.
  // ************************************************************
  task automatic wr_mode(input int m, input logic [7:0] d);
    sfr_addr  = 8'(MODULE0_MODE_CONTROL_ADDR + m);
    sfr_wdata = d;
    sfr_wr    = 1'b1;
    @(negedge clk);
    sfr_wr = 1'b0;
    @(negedge clk);
  endtask : wr_mode

  task automatic wr_cmp(input int m, input logic hi, input logic [7:0] d);
    sfr_wdata = d;
    if (hi) high_wr[m] = 1'b1;
    else low_wr[m] = 1'b1;
    @(negedge clk);
    low_wr  = 3'b000;
    high_wr = 3'b000;
    @(negedge clk);
  endtask : wr_cmp

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    sfr_addr = a;
    #1;
    `CHK("mode register", exp, sfr_rdata)
  endtask : rd_chk

  task automatic run_period();
    highs = '{0, 0, 0};
    for (int c = 0; c < 256; c++) begin
      count     = c[7:0];
      count_inc = 1'b1;
      #1;
      for (int m = 0; m < 3; m++) if (pin[m] === 1'b1) highs[m]++;
      @(negedge clk);
    end
    count_inc = 1'b0;
  endtask : run_period

  task automatic test_done();
    if (n_mismatch == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : test_done

  // ************************************************************
  // Test sequence.
  // ************************************************************
  initial begin
    logic [7:0] ks [2][3];
    logic [7:0] modes [3];
    ks = '{'{8'h00, 8'h80, 8'hFF}, '{8'h01, 8'h40, 8'hC0}};
    modes = '{8'h02, 8'hC2, 8'h40};
    resetn = 1'b0; sfr_wr = 1'b0; sfr_addr = 8'h00; sfr_wdata = 8'h00;
    low_wr = 3'b000; high_wr = 3'b000; count = 8'h00; count_inc = 1'b0;
    n_mismatch = 0; checked = 0;
    repeat (2) @(negedge clk);
    resetn = 1'b1;
    for (int m = 0; m < 3; m++) rd_chk(8'(MODULE0_MODE_CONTROL_ADDR + m), MODE_RESET_VALUE);
    rd_chk(8'hDD, 8'h00);
    `CHK("pins after reset", 3'b000, pin)
    wr_mode(1, 8'h3D);
    rd_chk(MODULE1_MODE_CONTROL_ADDR, 8'h3D);
    wr_cmp(0, 1'b1, 8'h80);
    rd_chk(MODULE0_MODE_CONTROL_ADDR, 8'h40);
    wr_cmp(0, 1'b0, 8'h10);
    rd_chk(MODULE0_MODE_CONTROL_ADDR, 8'h00);
    for (int s = 0; s < 2; s++) begin
      for (int m = 0; m < 3; m++) begin
        wr_cmp(m, 1'b0, 8'h10);
        wr_cmp(m, 1'b1, ks[s][m]);
        wr_mode(m, 8'h42);
      end
      run_period();
      for (int m = 0; m < 3; m++) `CHK("reloaded low byte", ks[s][m], cmp_low[8*m+:8])
      run_period();
      for (int m = 0; m < 3; m++) `CHK("high cycles", 256 - int'(ks[s][m]), highs[m])
    end
    for (int i = 0; i < 3; i++) begin
      for (int m = 0; m < 3; m++) begin
        wr_cmp(m, 1'b0, 8'h33);
        wr_cmp(m, 1'b1, 8'h44);
        wr_mode(m, modes[i]);
      end
      run_period();
      for (int m = 0; m < 3; m++) `CHK("disabled high cycles", 0, highs[m])
      for (int m = 0; m < 3; m++) `CHK("unreloaded low byte", 8'h33, cmp_low[8*m+:8])
    end
    test_done();
  end

  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    test_done();
  end
endmodule : tb_top
